// >>> design/rth_top.sv
// Design decisions made here: the APB slave port and the address map.
`include "rth_defines.svh"
`default_nettype none
module rth_top
    import rth_pkg::*;
(
    input  wire logic        clock_in,             // 40 MHz system clock
    input  wire logic        reset_n_in,           // async reset, active low
    input  wire logic        ce_in,                // clock enable, freezes all
    input  wire logic        psel_in,              // apb select
    input  wire logic        penable_in,           // apb enable
    input  wire logic        pwrite_in,            // apb write
    input  wire logic [7:0]  paddr_in,             // apb byte address
    input  wire logic [31:0] pwdata_in,            // apb write data
    output logic      [31:0] prdata_out,           // apb read data
    output logic             pready_out,           // apb ready
    output logic             pslverr_out,          // apb error
    input  wire logic        origin_seek_request_in,     // host start pin
    input  wire logic        position_preset_request_in, // host preset pin
    input  wire logic        home_sensor_in,       // home sensor
    input  wire logic        end_limit_pos_in,     // positive end limit
    input  wire logic        end_limit_neg_in,     // negative end limit
    input  wire logic        index_slot_in,        // slot sensor
    input  wire logic        step_phase_timing_in, // phase timing signal
    input  wire logic        encoder_index_in,     // encoder index
    input  wire logic        step_done_in,         // one pulse per step taken
    output logic             ready_out,            // idle, accepts a start
    output logic             origin_reached_out,   // homing complete
    output logic             moving_out,           // motor commanded to move
    output logic             dir_out,              // high positive direction
    output logic      [19:0] speed_out,            // commanded speed, Hz
    output logic      [19:0] accel_out             // commanded accel setting
);
    rth_cfg_t           cfg;        // software settings
    rth_state_t         state;      // sequencer state
    rth_pins_t          pins_raw;   // pin bundle before filter
    rth_pins_t          pins;       // filtered levels
    rth_pins_t          pins_q;     // previous filtered levels
    logic signed [31:0] position;   // command position
    logic [23:0]        step_cnt;   // steps in current segment
    logic [23:0]        off_mag;    // offset magnitude
    logic [19:0]        final_speed;// capped final speed
    logic               home_rise;  // home sensor on edge
    logic               seek_rise;  // start request edge
    logic               preset_rise;// preset request edge
    logic               lim_ahead;  // limit in travel direction
    logic               lim_behind; // limit opposite to travel
    logic               qual_need;  // any qualifier enabled
    logic               qual_ok;    // qualifiers satisfied
    logic               apb_setup;  // access phase, first cycle
    logic               apb_done;   // access completes this edge

    assign pins_raw = '{home: home_sensor_in, lim_pos: end_limit_pos_in,
                        lim_neg: end_limit_neg_in, index_slot_input: index_slot_in,
                        tim: step_phase_timing_in, encoder_index_output: encoder_index_in,
                        seek_req: origin_seek_request_in,
                        preset_req: position_preset_request_in};

    // all sensor and request pins pass the three-stage filter; step_done_in is used unfiltered
    rth_sync #(
        .W($bits(rth_pins_t))
    ) u_sync (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .ce_in      (ce_in),
        .d_in       (pins_raw),
        .q_out      (pins)
    );

    // previous levels for edge detection
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pins_q <= '0;
        end else if (ce_in) begin
            pins_q <= pins;
        end
    end

    assign home_rise   = pins.home & ~pins_q.home;
    // start only on the request edge while ready
    assign seek_rise   = pins.seek_req & ~pins_q.seek_req;
    assign preset_rise = pins.preset_req & ~pins_q.preset_req;
    assign lim_ahead   = dir_out ? pins.lim_pos : pins.lim_neg;
    assign lim_behind  = dir_out ? pins.lim_neg : pins.lim_pos;
    // two's complement magnitude, -8388608 fits as unsigned
    assign off_mag     = cfg.offset[23] ? 24'(-cfg.offset) : 24'(cfg.offset);
    assign final_speed = (cfg.start_speed < `RTH_FINAL_CAP) ? cfg.start_speed
                                                            : `RTH_FINAL_CAP;

    // slot and timing qualifiers; select 3 acts as off
    always_comb begin
        qual_need = cfg.index_slot_input_en | (cfg.tim_sel == `RTH_TIM_PHASE)
                  | (cfg.tim_sel == `RTH_TIM_ENC);
        qual_ok   = 1'b1;
        if (cfg.index_slot_input_en) begin
            qual_ok = pins.index_slot_input;
        end
        if (cfg.tim_sel == `RTH_TIM_PHASE) begin
            qual_ok = qual_ok & pins.tim;
        end else if (cfg.tim_sel == `RTH_TIM_ENC) begin
            qual_ok = qual_ok & pins.encoder_index_output;
        end
    end

    // sequencer, also owns direction, ready and reached flags
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state              <= S_IDLE;
            dir_out            <= `RTH_RST_DIR;
            ready_out          <= 1'b1;
            origin_reached_out <= 1'b0;
            step_cnt           <= '0;
        end else if (ce_in) begin
            case (state)
                S_IDLE: begin
                    if (seek_rise && ready_out) begin
                        dir_out            <= cfg.dir;
                        ready_out          <= 1'b0;
                        origin_reached_out <= 1'b0;
                        state              <= S_SEEK;
                    end
                end
                S_SEEK: begin
                    if (lim_ahead) begin
                        dir_out <= ~dir_out;
                        if (cfg.mode != `RTH_MODE_THREE) begin
                            state <= S_REV;
                        end
                    end else if (cfg.mode == `RTH_MODE_THREE && home_rise) begin
                        // first home edge, reverse without stopping; moving stays high
                        dir_out <= ~dir_out;
                        state   <= S_REV;
                    end
                end
                S_REV: begin
                    if (cfg.mode == `RTH_MODE_THREE) begin
                        if (home_rise) begin
                            state <= S_QUAL;
                        end
                    end else if (!lim_behind) begin
                        step_cnt <= '0;
                        state    <= S_BACK;
                    end
                end
                S_BACK: begin
                    if (step_cnt == cfg.back_steps) begin
                        state <= S_QUAL;
                    end else if (step_done_in) begin
                        step_cnt <= step_cnt + 24'h000001;
                    end
                end
                S_QUAL: begin
                    if (!qual_need || qual_ok) begin
                        step_cnt <= '0;
                        dir_out  <= ~cfg.offset[23];
                        state    <= S_OFFS;
                    end
                end
                S_OFFS: begin
                    // offset move ends at electrical home
                    if (step_cnt == off_mag) begin
                        state <= S_DONE;
                    end else if (step_done_in) begin
                        step_cnt <= step_cnt + 24'h000001;
                    end
                end
                S_DONE: begin
                    origin_reached_out <= 1'b1;
                    ready_out          <= 1'b1;
                    state              <= S_IDLE;
                end
                default: begin
                    state     <= S_IDLE;
                    ready_out <= 1'b1;
                end
            endcase
        end
    end

    // commanded speed per segment; accel passed straight on
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            speed_out  <= '0;
            accel_out  <= `RTH_RST_ACCEL;
            moving_out <= 1'b0;
        end else if (ce_in) begin
            // accel setting feeds the pulse generator
            accel_out  <= cfg.accel;
            // moving in every motion state; drops as the offset count
            // is met, so no stray step lands after position is zeroed
            moving_out <= (state inside {S_SEEK, S_REV, S_BACK, S_QUAL})
                        || (state == S_OFFS && step_cnt != off_mag);
            case (state)
                S_SEEK: begin
                    // run speed or start speed by mode
                    speed_out <= (cfg.mode == `RTH_MODE_THREE) ? cfg.run_speed
                                                               : cfg.start_speed;
                end
                S_REV: begin
                    speed_out <= (cfg.mode == `RTH_MODE_THREE) ? final_speed
                                                               : cfg.start_speed;
                end
                S_BACK, S_QUAL, S_OFFS: begin
                    speed_out <= final_speed;
                end
                default: begin
                    speed_out <= '0;
                end
            endcase
        end
    end

    // command position; preset only honoured while stopped
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            position <= '0;
        end else if (ce_in) begin
            if (state == S_IDLE && !moving_out && preset_rise) begin
                position <= cfg.preset;
            end else if (state == S_DONE) begin
                // electrical home reads as zero
                position <= '0;
            end else if (step_done_in) begin
                position <= dir_out ? position + 32'sh00000001
                                    : position - 32'sh00000001;
            end
        end
    end

    // apb: one wait state, so read data comes from a flop
    assign apb_setup = psel_in & penable_in & ~pready_out;
    assign apb_done  = psel_in & penable_in & pready_out;

    // ready, error and read data
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end else if (ce_in) begin
            pready_out  <= apb_setup;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
            if (apb_setup) begin
                if (paddr_in == `RTH_OFF_CTRL) begin
                    prdata_out[`RTH_CTRL_MODE] <= cfg.mode;
                    prdata_out[`RTH_CTRL_DIR]  <= cfg.dir;
                    prdata_out[`RTH_CTRL_INDEX_SLOT_INPUT] <= cfg.index_slot_input_en;
                    prdata_out[`RTH_CTRL_TIM_HI:`RTH_CTRL_TIM_LO] <= cfg.tim_sel;
                end else if (paddr_in == `RTH_OFF_RUN) begin
                    prdata_out <= 32'(cfg.run_speed);
                end else if (paddr_in == `RTH_OFF_START) begin
                    prdata_out <= 32'(cfg.start_speed);
                end else if (paddr_in == `RTH_OFF_ACCEL) begin
                    prdata_out <= 32'(cfg.accel);
                end else if (paddr_in == `RTH_OFF_OFFSET) begin
                    prdata_out <= 32'(cfg.offset);
                end else if (paddr_in == `RTH_OFF_BACK) begin
                    prdata_out <= 32'(cfg.back_steps);
                end else if (paddr_in == `RTH_OFF_PRESET) begin
                    prdata_out <= cfg.preset;
                end else if (paddr_in == `RTH_OFF_POSITION) begin
                    prdata_out <= position;
                end else if (paddr_in == `RTH_OFF_STATUS) begin
                    prdata_out <= {22'h0, state, moving_out,
                                   origin_reached_out, ready_out};
                end else begin
                    // unmapped: error, data zero
                    pslverr_out <= 1'b1;
                end
            end
        end
    end

    // settings writes, taken at the completing edge only
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg <= '{mode: `RTH_RST_MODE, dir: `RTH_RST_DIR, index_slot_input_en: `RTH_RST_INDEX_SLOT_INPUT,
                     tim_sel: `RTH_RST_TIM, run_speed: `RTH_RST_RUN,
                     start_speed: `RTH_RST_START, accel: `RTH_RST_ACCEL,
                     offset: `RTH_RST_OFFSET, back_steps: `RTH_RST_BACK,
                     preset: `RTH_RST_PRESET};
        end else if (ce_in && apb_done && pwrite_in) begin
            // changing settings mid-seek takes effect at once; not blocked
            if (paddr_in == `RTH_OFF_CTRL) begin
                cfg.mode    <= pwdata_in[`RTH_CTRL_MODE];
                cfg.dir     <= pwdata_in[`RTH_CTRL_DIR];
                cfg.index_slot_input_en <= pwdata_in[`RTH_CTRL_INDEX_SLOT_INPUT];
                cfg.tim_sel <= pwdata_in[`RTH_CTRL_TIM_HI:`RTH_CTRL_TIM_LO];
            end else if (paddr_in == `RTH_OFF_RUN) begin
                cfg.run_speed <= pwdata_in[19:0];
            end else if (paddr_in == `RTH_OFF_START) begin
                cfg.start_speed <= pwdata_in[19:0];
            end else if (paddr_in == `RTH_OFF_ACCEL) begin
                cfg.accel <= pwdata_in[19:0];
            end else if (paddr_in == `RTH_OFF_OFFSET) begin
                cfg.offset <= pwdata_in[23:0];
            end else if (paddr_in == `RTH_OFF_BACK) begin
                cfg.back_steps <= pwdata_in[23:0];
            end else if (paddr_in == `RTH_OFF_PRESET) begin
                cfg.preset <= pwdata_in;
            end
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    a_preset_load: assert property (
        ce_in && state == S_IDLE && !moving_out && preset_rise
        |=> position == $past(cfg.preset))
        else $error("preset not loaded");
    a_run_speed_three: assert property (
        ce_in && state == S_SEEK && cfg.mode
        |=> speed_out == $past(cfg.run_speed))
        else $error("three-sensor seek speed wrong");
    a_start_speed_two: assert property (
        ce_in && state == S_SEEK && !cfg.mode
        |=> speed_out == $past(cfg.start_speed))
        else $error("two-sensor seek speed wrong");
    a_final_speed_cap: assert property (
        ce_in && state == S_QUAL
        |=> speed_out == ($past(cfg.start_speed) < `RTH_FINAL_CAP ?
                          $past(cfg.start_speed) : `RTH_FINAL_CAP))
        else $error("final speed not capped");
    a_ready_drops: assert property (
        ce_in && state == S_IDLE && seek_rise && ready_out
        |=> !ready_out && state == S_SEEK ##1 !ready_out)
        else $error("ready did not drop");
    a_home_flag_set: assert property (
        ce_in && state == S_DONE |=> origin_reached_out && ready_out)
        else $error("reached flag missing");
    a_moving_tracks: assert property (
        ce_in && (state == S_SEEK || state == S_REV
                  || (state == S_OFFS && step_cnt != off_mag)) |=> moving_out)
        else $error("moving low during motion");
    a_moving_stops: assert property (
        ce_in && state == S_DONE |=> !moving_out)
        else $error("moving high after homing");
    a_start_dir_set: assert property (
        ce_in && state == S_IDLE && seek_rise && ready_out
        |=> dir_out == $past(cfg.dir))
        else $error("start direction wrong");
    a_back_steps_end: assert property (
        ce_in && state == S_BACK && step_cnt == cfg.back_steps
        |=> state == S_QUAL)
        else $error("backward steps overrun");
endmodule : rth_top
`default_nettype wire

// >>> common/rth_defines.svh
// Overview of operation
// - preset request while stopped loads preset position
// - mode 0 two-sensor, 1 three-sensor, default 1
// - run speed 1 to 1,000,000 Hz, default 1000
// - accel setting 1 to 1,000,000, default 30000
// - start speed 1 to 1,000,000 Hz, default 100
// - signed 24-bit home offset, default zero
// - start direction 0 negative, 1 positive, default 1
// - two-sensor travels backward steps after leaving limit
// - index slot qualifies home only when enabled
// - timing qualifier 0 off, 1 phase, 2 encoder
// - ready drops at start; host then releases request
// - home reached flag set when homing completes
// - final speed is start speed capped at 500 Hz
// - three-sensor stops on home edge, reverses, stops again; the code keeps moving_out high through both home edges
// - two-sensor reverses off limit then backward steps
// - offset move after mechanical home gives electrical home
`ifndef RTH_DEFINES_SVH
`define RTH_DEFINES_SVH

// register byte offsets
`define RTH_OFF_CTRL     8'h00
`define RTH_OFF_RUN      8'h04
`define RTH_OFF_START    8'h08
`define RTH_OFF_ACCEL    8'h0C
`define RTH_OFF_OFFSET   8'h10
`define RTH_OFF_BACK     8'h14
`define RTH_OFF_PRESET   8'h18
`define RTH_OFF_POSITION 8'h1C
`define RTH_OFF_STATUS   8'h20

// control register field positions
`define RTH_CTRL_MODE    0
`define RTH_CTRL_DIR     1
`define RTH_CTRL_INDEX_SLOT_INPUT    2
`define RTH_CTRL_TIM_LO  4
`define RTH_CTRL_TIM_HI  5

// field encodings
`define RTH_MODE_THREE   1'h1
`define RTH_TIM_PHASE    2'h1
`define RTH_TIM_ENC      2'h2

// reset values
`define RTH_RST_MODE     1'h1
`define RTH_RST_DIR      1'h1
`define RTH_RST_INDEX_SLOT_INPUT     1'h0
`define RTH_RST_TIM      2'h0
`define RTH_RST_RUN      20'h003E8
`define RTH_RST_START    20'h00064
`define RTH_RST_ACCEL    20'h07530
`define RTH_RST_OFFSET   24'h000000
`define RTH_RST_BACK     24'h000000
`define RTH_RST_PRESET   32'h00000000

// final speed ceiling in Hz
`define RTH_FINAL_CAP    20'h001F4

`endif

// >>> common/rth_pkg.sv
`default_nettype none
package rth_pkg;

    // sequencer states, one-hot
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_SEEK = 7'h02,
        S_REV  = 7'h04,
        S_BACK = 7'h08,
        S_QUAL = 7'h10,
        S_OFFS = 7'h20,
        S_DONE = 7'h40
    } rth_state_t;

    // software settings
    typedef struct packed {
        logic               mode;        // three-sensor when high
        logic               dir;         // start direction, high positive
        logic               index_slot_input_en;     // index slot qualification
        logic [1:0]         tim_sel;     // timing qualifier select
        logic [19:0]        run_speed;   // Hz
        logic [19:0]        start_speed; // Hz
        logic [19:0]        accel;       // accel/decel setting
        logic signed [23:0] offset;      // steps from mechanical home
        logic [23:0]        back_steps;  // two-sensor travel
        logic signed [31:0] preset;      // preset position
    } rth_cfg_t;

    // external levels after filtering
    typedef struct packed {
        logic home;
        logic lim_pos;
        logic lim_neg;
        logic index_slot_input;
        logic tim;
        logic encoder_index_output;
        logic seek_req;
        logic preset_req;
    } rth_pins_t;

endpackage : rth_pkg
`default_nettype wire

// >>> design/rth_sync.sv
`default_nettype none
module rth_sync #(
    parameter int W = 8
) (
    input  wire logic         clock_in,   // system clock
    input  wire logic         reset_n_in, // async reset, active low
    input  wire logic         ce_in,      // clock enable
    input  wire logic [W-1:0] d_in,       // raw pin levels
    output logic      [W-1:0] q_out       // filtered levels
);
    logic [W-1:0] s1; // first stage, read only by s2
    logic [W-1:0] s2; // second stage
    logic [W-1:0] s3; // third stage

    // three-stage shift; a bit changes only once s2 and s3 agree
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            q_out <= '0;
        end else if (ce_in) begin
            s1    <= d_in;
            s2    <= s1;
            s3    <= s2;
            // per bit: take the agreed value, else hold
            q_out <= (s2 & s3) | (q_out & (s2 | s3));
        end
    end
endmodule : rth_sync
`default_nettype wire

// >>> tb/rth_axis_model.sv
`default_nettype none
module rth_axis_model (
    input  wire logic       clock_in,   // system clock
    input  wire logic       reset_n_in, // async reset, active low
    input  wire logic       moving_in,  // motion command
    input  wire logic       dir_in,     // high positive
    output logic            step_out,   // one pulse per step
    output logic      [5:0] sense_out   // home, +lim, -lim, slot, phase, index
);
    timeunit 1ns;
    timeprecision 100ps;
    int         pos;   // axis position in steps
    logic [2:0] div;   // eight clocks a step, so the pin filters see each mark
    logic       dir_q; // direction the axis really turns
    logic       coast; // one step already run the old way after a reversal
    // stepping axis; a reversal coasts two steps on before it bites, so the
    // home mark is crossed again on the way back, as a decelerating load does
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pos      <= 0;
            div      <= 3'h0;
            dir_q    <= 1'b1;
            coast    <= 1'b0;
            step_out <= 1'b0;
        end else begin
            div      <= div + 3'h1;
            step_out <= moving_in && div == 3'h7;
            if (!moving_in) begin
                // a stopped axis turns either way at once
                dir_q <= dir_in;
                coast <= 1'b0;
            end else if (div == 3'h7) begin
                pos <= dir_q ? pos + 1 : pos - 1;
                if (dir_in == dir_q) begin
                    coast <= 1'b0;
                end else if (coast) begin
                    dir_q <= dir_in;
                    coast <= 1'b0;
                end else begin
                    coast <= 1'b1;
                end
            end
        end
    end
    // one-step home, end limits, marks aligned on home
    assign sense_out = {pos == 96, pos >= 300, pos <= -300,
                        pos[1:0] == 2'h0, pos[2:0] == 3'h0, pos[3:0] == 4'h0};
endmodule : rth_axis_model
`default_nettype wire

// >>> tb/rth_top_tb.sv
`default_nettype none
module rth_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, seek = 0, pre = 0, ce = 1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, cfg;
    logic        pready, pslverr, ready, reached, moving, dir, step, err;
    logic [19:0] speed, accel, vs, seen;
    logic [5:0]  sense;
    int          n_mismatch = 0, cmp_count = 0, seed = 32'h815d, i, n;
    logic [31:0] runs [4] = '{32'h03, 32'h16, 32'h21, 32'h34};
    rth_top uut (.clock_in(clk), .reset_n_in(rst_n), .ce_in(ce), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .origin_seek_request_in(seek), .position_preset_request_in(pre),
        .home_sensor_in(sense[5]), .end_limit_pos_in(sense[4]), .end_limit_neg_in(sense[3]),
        .index_slot_in(sense[2]), .step_phase_timing_in(sense[1]),
        .encoder_index_in(sense[0]), .step_done_in(step), .ready_out(ready),
        .origin_reached_out(reached), .moving_out(moving), .dir_out(dir),
        .speed_out(speed), .accel_out(accel));
    rth_axis_model axis (.clock_in(clk), .reset_n_in(rst_n), .moving_in(moving),
        .dir_in(dir), .step_out(step), .sense_out(sense));
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // final approach speed: start speed, capped at 500 Hz
    function automatic logic [19:0] exp_final(input logic [19:0] s);
        return (s < 20'h001F4) ? s : 20'h001F4;
    endfunction : exp_final
    // one apb transfer; holds everything until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    // one homing run with the given control word
    task automatic home_run(input logic [31:0] c);
        apb(1'b1, 8'h00, c);
        apb(1'b1, 8'h08, {12'h0, vs});
        apb(1'b1, 8'h14, {28'h0, 4'($random(seed)) | 4'h1});
        apb(1'b1, 8'h10, {{29{cfg[2]}}, 3'($random(seed))});
        chk(ready, 1'b1); // host sees ready first
        seek <= 1'b1;
        for (n = 0; ready !== 1'b0 && n < 50; n++) @(posedge clk);
        chk(ready, 1'b0); // ready drops at start
        repeat (3) @(posedge clk);
        seek <= 1'b0;
        chk(dir, c[1]); // start direction
        chk(speed, c[0] ? 20'h003E8 : vs); // seek speed per mode
        seen = 20'h0;
        for (n = 0; reached !== 1'b1 && n < 30000; n++) begin
            @(posedge clk);
            // speed follows the state a clock behind, so look one clock later
            if (moving === 1'b1 && dir !== c[1] && seen === 20'h0) begin
                @(posedge clk);
                seen = speed;
            end
        end
        chk(reached, 1'b1); // completion
        if (!c[0] || c[1]) chk(seen, !c[0] ? vs : exp_final(vs));
        repeat (2) @(posedge clk);
        chk({ready, moving}, 2'b10); // motion ends with homing
        apb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h0); // electrical home is zero
    endtask : home_run
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // watchdog sized well above four homing runs
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({ready, dir, accel}, 22'h3_07530); // pins after reset
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h3); // control defaults
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h3E8); // run speed default
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h64); // start speed default
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0); // offset default
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        for (i = 0; i < 4; i++) begin
            cfg = $random(seed);
            vs = 20'(cfg[9:0] % 1000 + 1);
            home_run(runs[i]);
        end
        cfg = $random(seed);
        apb(1'b1, 8'h18, cfg);
        ce  <= 1'b0;
        pre <= 1'b1;
        repeat (8) @(posedge clk);
        pre <= 1'b0;
        @(posedge clk);
        ce  <= 1'b1;
        apb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h0); // frozen block never sees the preset pulse
        pre <= 1'b1;
        repeat (8) @(posedge clk);
        pre <= 1'b0;
        repeat (8) @(posedge clk);
        apb(1'b0, 8'h1C, 32'h0);
        chk(rd, cfg); // preset loads position
        apb(1'b1, 8'h0C, cfg);
        repeat (2) @(posedge clk);
        chk(accel, cfg[19:0]); // accel setting reaches its output
        print_verdict();
    end
endmodule : rth_top_tb
`default_nettype wire
